// File: core/cio_port_top.sv
/*
  Four-port configurable I/O block: register decode and readback, pin input
  synchronisers, peripheral data buffer on the first port, and one register
  set plus one pin cell per port.
  Assumes the processor bus gives one-cycle read and write strobes on clock,
  and that pin levels arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cio_defs.svh"

module cio_port_top
  import cio_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr_strobe,
  input wire logic cpu_rd_strobe,
  output logic [7:0] cpu_rdata,
  output logic cpu_rdata_valid,
  input wire logic [7:0] addr_latched,
  input wire logic peripheral_buffer_bit,
  input wire logic peripheral_select_zero,
  input wire logic peripheral_select_one,
  input wire logic [7:0] periph_cpu_data,
  input wire logic periph_cpu_read,
  output logic [7:0] periph_rdata,
  input wire cio_pld_s pld_cfg [0:3],
  input wire logic [7:0] pin_in [0:3],
  output cio_pins_s pins [0:3]
);

  localparam logic [31:0] MODE_MASK = `CIO_MODE_MASK;
  localparam logic [31:0] DIR_MASK = `CIO_DIR_MASK;
  localparam logic [31:0] OD_MASK = `CIO_OD_MASK;
  localparam logic [31:0] SLEW_MASK = `CIO_SLEW_MASK;
  localparam logic [31:0] PLD_MASK = `CIO_PLD_MASK;
  localparam logic [31:0] PIN_MASK = `CIO_PIN_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: kind in the upper nibble, port in the low two bits
  wire logic [3:0] kind;
  wire logic [1:0] port_idx;
  wire logic pad_ok;
  wire logic hit_data_in;
  wire logic hit_data_out;
  wire logic hit_mode;
  wire logic hit_dir;
  wire logic hit_drive;
  wire logic hit_enable_out;
  wire logic hit_any;

  assign kind = cpu_addr[`CIO_KIND_FIELD];
  assign port_idx = cpu_addr[`CIO_PORT_FIELD];
  assign pad_ok = (cpu_addr[`CIO_PAD_FIELD] == `CIO_PAD_BITS);
  assign hit_data_in = pad_ok & (kind == `CIO_KIND_DATA_IN);
  assign hit_data_out = pad_ok & (kind == `CIO_KIND_DATA_OUT);
  assign hit_mode = pad_ok & (kind == `CIO_KIND_MODE);
  assign hit_dir = pad_ok & (kind == `CIO_KIND_DIR);
  assign hit_drive = pad_ok & (kind == `CIO_KIND_DRIVE);
  assign hit_enable_out = pad_ok & (kind == `CIO_KIND_ENABLE_OUT);
  assign hit_any = hit_data_in | hit_data_out | hit_mode | hit_dir |
                   hit_drive | hit_enable_out;

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral buffer control on the first port
  wire logic sel_any;
  wire logic periph_oe;

  assign sel_any = peripheral_select_zero | peripheral_select_one;
  // R07 drive only while selected
  // R08 relies on selects already qualified by the program-store strobe
  assign periph_oe = sel_any & ~periph_cpu_read;

  ////////////////////////////////////////////////////////////////////////////
  // Per-port storage, drivers and input synchronisers
  cio_cfg_s cfg [0:3];
  logic [7:0] sync1_q [0:3];
  logic [7:0] sync2_q [0:3];
  logic [7:0] sync3_q [0:3];
  logic [7:0] pin_stable_q [0:3];
  logic [7:0] rd_data_in [0:3];
  logic [7:0] rd_data_out [0:3];
  logic [7:0] rd_mode [0:3];
  logic [7:0] rd_dir [0:3];
  logic [7:0] rd_drive [0:3];
  logic [7:0] rd_enable_out [0:3];

  genvar p;
  generate
    for (p = 0; p < `CIO_NPORTS; p++) begin : g_port
      wire logic this_port;
      wire cio_wr_s wr;
      wire logic port_periph_en;

      assign this_port = (port_idx == p[1:0]);
      // R14 write strobes per register
      assign wr.mode = cpu_wr_strobe & this_port & hit_mode;
      assign wr.dir = cpu_wr_strobe & this_port & hit_dir;
      assign wr.drive = cpu_wr_strobe & this_port & hit_drive;
      assign wr.dout = cpu_wr_strobe & this_port & hit_data_out;

      cio_cfg_regs #(
        .MODE_MASK(MODE_MASK[p*8 +: 8]),
        .DIR_MASK(DIR_MASK[p*8 +: 8])
      ) u_regs (
        .clock(clock),
        .reset_n(reset_n),
        .wr(wr),
        .wdata(cpu_wdata),
        .cfg(cfg[p])
      );

      // R06 whole first port becomes the buffer
      assign port_periph_en = (p == 0) ? peripheral_buffer_bit : 1'b0;

      cio_pin_cell #(
        .MODE_MASK(MODE_MASK[p*8 +: 8]),
        .OD_MASK(OD_MASK[p*8 +: 8]),
        .SLEW_MASK(SLEW_MASK[p*8 +: 8]),
        .PLD_MASK(PLD_MASK[p*8 +: 8]),
        .PIN_MASK(PIN_MASK[p*8 +: 8])
      ) u_pins (
        .cfg(cfg[p]),
        .pld(pld_cfg[p]),
        .addr_bits(addr_latched),
        .periph_en(port_periph_en),
        .periph_oe(periph_oe),
        .periph_data(periph_cpu_data),
        .pins(pins[p])
      );

      // Three-stage synchroniser; a change counts once stages two and three agree,
      // which rejects a single-cycle glitch at the cost of one extra cycle
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          sync1_q[p] <= `CIO_ZERO;
          sync2_q[p] <= `CIO_ZERO;
          sync3_q[p] <= `CIO_ZERO;
        end else begin
          sync1_q[p] <= pin_in[p];
          sync2_q[p] <= sync1_q[p];
          sync3_q[p] <= sync2_q[p];
        end
      end

      // Accepted level per bit
      for (genvar b = 0; b < 8; b++) begin : g_bit
        always_ff @(posedge clock or negedge reset_n) begin
          if (!reset_n) begin
            pin_stable_q[p][b] <= 1'b0;
          end else if (sync2_q[p][b] == sync3_q[p][b]) begin
            pin_stable_q[p][b] <= sync3_q[p][b];
          end
        end
      end

      // Readback sources; absent pins read zero in data-in, direction and enable-out, and absent mode registers read zero
      // R19 data-in reads pin level
      assign rd_data_in[p] = pin_stable_q[p] & PIN_MASK[p*8 +: 8];
      assign rd_data_out[p] = cfg[p].dout;
      assign rd_mode[p] = cfg[p].mode;
      assign rd_dir[p] = cfg[p].dir;
      assign rd_drive[p] = cfg[p].drive;
      assign rd_enable_out[p] = pins[p].oe;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read selection; unmapped addresses return zero
  wire logic [7:0] rd_sel;

  // R14 readback mux
  assign rd_sel = !hit_any ? `CIO_ZERO :
                  hit_data_in ? rd_data_in[port_idx] :
                  hit_data_out ? rd_data_out[port_idx] :
                  hit_mode ? rd_mode[port_idx] :
                  hit_dir ? rd_dir[port_idx] :
                  hit_drive ? rd_drive[port_idx] : rd_enable_out[port_idx];

  // Read data registered; valid pulses the cycle after the strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cpu_rdata <= `CIO_ZERO;
      cpu_rdata_valid <= 1'b0;
    end else begin
      cpu_rdata_valid <= cpu_rd_strobe;
      if (cpu_rd_strobe) begin
        cpu_rdata <= rd_sel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral read path: first-port pins captured while the CPU reads
  // R06 R07 inbound buffer direction
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      periph_rdata <= `CIO_ZERO;
    end else if (peripheral_buffer_bit & sel_any & periph_cpu_read) begin
      periph_rdata <= pin_stable_q[0];
    end
  end

endmodule : cio_port_top

`default_nettype wire

// File: core/cio_defs.svh
/*
  Constants for the configurable I/O port block: register map, field masks,
  reset values and per-port capability masks.
  Assumes inclusion by bare name from every core file that needs them.
*/
// Notes on behaviour
// R01 - PLD output tri-states when its enable term is off and direction bit is 0.
// R02 - Software keeps direction 0 on any pin used as a PLD input.
// R03 - Address drives a pin when enable term is on, or direction and mode both 1.
// R04 - Software sets address-output mode at run time through mode and direction.
// R05 - Address pins: low nibble carries address 3..0, high nibble carries 7..4.
// R06 - Buffer-enable bit 1 turns the whole first port into the data bus buffer.
// R07 - Peripheral buffer drives only while a peripheral select is active.
// R08 - Select equations should include program-store strobe to avoid data space.
// R09 - Mode bit 0 is processor I/O, 1 is address output; first two ports only.
// R10 - Direction bit 1 is output, 0 is input; all pins reset to input.
// R11 - Output enable is direction bit OR enable term.
// R12 - Register bit n controls pin n of the same port.
// R13 - All configuration registers reset to zero.
// R14 - Processor writes and reads back configuration registers at fixed offsets.
// R15 - Drive bit 1 makes an open-drain capable pin open-drain; default push-pull.
// R16 - Drive bit 1 selects fast slew on slew pins; default slow.
// R17 - Fourth port direction register keeps only its two pin bits.
// R18 - Third port takes cell outputs on pins 2,3,4,7; address only on ports 0,1.
// R19 - Processor I/O drives data-out register; inputs read through data-in.
// R20 - Open-drain pin drives low on 0 and floats on 1 or when disabled.
`ifndef CIO_DEFS_SVH
`define CIO_DEFS_SVH

`define CIO_NPORTS 4
`define CIO_RST_VAL 8'h00
`define CIO_ZERO 8'h00

// Register kind lives in address bits 7..4, port index in bits 1..0
`define CIO_KIND_DATA_IN 4'h0
`define CIO_KIND_DATA_OUT 4'h1
`define CIO_KIND_MODE 4'h2
`define CIO_KIND_DIR 4'h3
`define CIO_KIND_DRIVE 4'h4
`define CIO_KIND_ENABLE_OUT 4'h5
`define CIO_PAD_BITS 2'h0

// Address fields: register kind, padding that must be zero, port index
`define CIO_KIND_FIELD 7:4
`define CIO_PAD_FIELD 3:2
`define CIO_PORT_FIELD 1:0

// Capability masks per port index 0..3
`define CIO_MODE_MASK {8'h00, 8'h00, 8'hFF, 8'hFF}
`define CIO_DIR_MASK {8'h06, 8'hFF, 8'hFF, 8'hFF}
`define CIO_OD_MASK {8'h00, 8'hFF, 8'hF0, 8'hF0}
`define CIO_SLEW_MASK {8'h06, 8'h00, 8'h0F, 8'h0F}
`define CIO_PLD_MASK {8'h06, 8'h9C, 8'hFF, 8'hFF}
`define CIO_PIN_MASK {8'h06, 8'hFF, 8'hFF, 8'hFF}

`endif

// File: core/cio_pkg.sv
/*
  Types shared by the configurable I/O port block.
  Assumes cio_defs.svh supplies the numeric constants.
*/
package cio_pkg;

  // Configuration and data-out registers of one port
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] dir;
    logic [7:0] drive;
    logic [7:0] dout;
  } cio_cfg_s;

  // Pad-facing signals of one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] fast;
  } cio_pins_s;

  // Programmable-logic hookup of one port, fixed by configuration
  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] data;
    logic [7:0] oe_term;
  } cio_pld_s;

  // Per-port write strobes, one per writable register
  typedef struct packed {
    logic mode;
    logic dir;
    logic drive;
    logic dout;
  } cio_wr_s;

endpackage : cio_pkg

// File: core/cio_cfg_regs.sv
/*
  Configuration register set of one port: mode, direction, drive, data out.
  Assumes one-cycle write strobes from the top-level decoder.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cio_defs.svh"

module cio_cfg_regs
  import cio_pkg::*;
#(
  parameter logic [7:0] MODE_MASK = 8'hFF,
  parameter logic [7:0] DIR_MASK = 8'hFF
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire cio_wr_s wr,
  input wire logic [7:0] wdata,
  output cio_cfg_s cfg
);

  cio_cfg_s cfg_q;
  cio_cfg_s cfg_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next values; unimplemented mode and direction bits stay zero so reads show them as zero
  // R09 mode only where capable
  // R17 direction mask
  always_comb begin
    cfg_d = cfg_q;
    if (wr.mode) begin
      cfg_d.mode = wdata & MODE_MASK;
    end
    if (wr.dir) begin
      cfg_d.dir = wdata & DIR_MASK;
    end
    if (wr.drive) begin
      cfg_d.drive = wdata;
    end
    if (wr.dout) begin
      cfg_d.dout = wdata;
    end
  end

  // R13 reset to zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= {`CIO_RST_VAL, `CIO_RST_VAL, `CIO_RST_VAL, `CIO_RST_VAL};
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg = cfg_q;

endmodule : cio_cfg_regs

`default_nettype wire

// File: core/cio_pin_cell.sv
/*
  Output multiplexer and driver control for the eight pins of one port.
  Assumes registered configuration and a stable programmable-logic hookup.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cio_defs.svh"

module cio_pin_cell
  import cio_pkg::*;
#(
  parameter logic [7:0] MODE_MASK = 8'hFF,
  parameter logic [7:0] OD_MASK = 8'h00,
  parameter logic [7:0] SLEW_MASK = 8'h00,
  parameter logic [7:0] PLD_MASK = 8'hFF,
  parameter logic [7:0] PIN_MASK = 8'hFF
) (
  input wire cio_cfg_s cfg,
  input wire cio_pld_s pld,
  input wire logic [7:0] addr_bits,
  input wire logic periph_en,
  input wire logic periph_oe,
  input wire logic [7:0] periph_data,
  output cio_pins_s pins
);

  ////////////////////////////////////////////////////////////////////////////
  // One slice per pin; bit i of every register steers pin i
  // R12 bit per pin
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      wire logic pld_use;
      wire logic addr_use;
      wire logic src;
      wire logic oe_raw;
      wire logic od;
      // R18 cell outputs only on capable pins
      assign pld_use = pld.sel[i] & PLD_MASK[i];
      // R09 mode bit picks address
      assign addr_use = cfg.mode[i] & MODE_MASK[i];
      // R05 R19 source priority
      assign src = periph_en ? periph_data[i] :
                   pld_use ? pld.data[i] :
                   addr_use ? addr_bits[i] : cfg.dout[i];
      // R01 R03 R10 R11 enable is OR of terms
      assign oe_raw = PIN_MASK[i] &
                      (periph_en ? periph_oe : (cfg.dir[i] | pld.oe_term[i]));
      // R15 open-drain select
      assign od = cfg.drive[i] & OD_MASK[i];
      // R20 open-drain pulls low only
      assign pins.out[i] = od ? 1'b0 : src;
      assign pins.oe[i] = od ? (oe_raw & ~src) : oe_raw;
      // R16 fast slew select
      assign pins.fast[i] = cfg.drive[i] & SLEW_MASK[i];
    end
  endgenerate

endmodule : cio_pin_cell

`default_nettype wire

// File: bench/cio_port_properties.sv
/* Checker for the I/O port block: bus answers, peripheral buffer, enables.
   Assumes it is bound to cio_port_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none

module cio_port_checker
  import cio_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cpu_rd_strobe,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_rdata_valid,
  input wire logic peripheral_buffer_bit,
  input wire logic peripheral_select_zero,
  input wire logic peripheral_select_one,
  input wire logic [7:0] periph_cpu_data,
  input wire logic periph_cpu_read,
  input wire cio_pld_s pld_cfg [0:3],
  input wire cio_pins_s pins [0:3]
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Either select term opens the buffer
  wire logic sel_any = peripheral_select_zero | peripheral_select_one;

  ////////////////////////////////////////
  // Register bus answers
  sequence s_lone_read;
    cpu_rd_strobe ##1 !cpu_rd_strobe;
  endsequence
  property p_read_answer;
    s_lone_read |-> cpu_rdata_valid ##1 !cpu_rdata_valid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer is not a single pulse");
  property p_valid_cause;
    cpu_rdata_valid |-> $past(cpu_rd_strobe);
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("read valid without a read");
  property p_rdata_stands;
    !cpu_rd_strobe |=> $stable(cpu_rdata);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands)
    else $error("read data moved without a read");
  property p_reset_clear;
    $rose(reset_n) |-> cpu_rdata == 8'h00 && !cpu_rdata_valid && pins[0].fast == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not clear after reset");

  ////////////////////////////////////////
  // Pin drivers
  property p_periph_drive;
    peripheral_buffer_bit && sel_any && !periph_cpu_read
      |-> pins[0].oe[3:0] == 4'hF && pins[0].out[3:0] == periph_cpu_data[3:0];
  endproperty
  a_periph_drive: assert property (p_periph_drive)
    else $error("peripheral buffer not driving");
  property p_periph_float;
    peripheral_buffer_bit && !sel_any |-> pins[0].oe == 8'h00;
  endproperty
  a_periph_float: assert property (p_periph_float)
    else $error("peripheral buffer drives unselected");
  property p_enable_or;
    (pins[3].oe[2:1] & pld_cfg[3].oe_term[2:1]) == pld_cfg[3].oe_term[2:1];
  endproperty
  a_enable_or: assert property (p_enable_or)
    else $error("enable term ignored");
  property p_port_d_pins;
    (pins[3].oe & 8'hF9) == 8'h00 && (pins[3].fast & 8'hF9) == 8'h00;
  endproperty
  a_port_d_pins: assert property (p_port_d_pins)
    else $error("absent pin enabled");
  property p_slew_caps;
    pins[2].fast == 8'h00 && pins[1].fast[7:4] == 4'h0;
  endproperty
  a_slew_caps: assert property (p_slew_caps)
    else $error("fast slew on a pin without slew control");
endmodule : cio_port_checker

bind cio_port_top cio_port_checker u_chk (
  .clock(clock), .reset_n(reset_n), .cpu_rd_strobe(cpu_rd_strobe),
  .cpu_rdata(cpu_rdata), .cpu_rdata_valid(cpu_rdata_valid),
  .peripheral_buffer_bit(peripheral_buffer_bit),
  .peripheral_select_zero(peripheral_select_zero),
  .peripheral_select_one(peripheral_select_one), .periph_cpu_data(periph_cpu_data),
  .periph_cpu_read(periph_cpu_read), .pld_cfg(pld_cfg), .pins(pins)
);
`default_nettype wire

// File: bench/cio_pin_model.sv
/* Far side of the port pins: external drivers and pull-up resistors.
   Assumes pins come straight from cio_port_top, oe high while driving. */
`timescale 1ns/1ps
`default_nettype none

module cio_pin_model
  import cio_pkg::*;
(
  input wire cio_pins_s pins [0:3],
  input wire logic [7:0] ext_val [0:3],
  input wire logic [7:0] ext_en [0:3],
  output logic [7:0] pin_in [0:3]
);
  // Device driver wins, then the outside part; an undriven pin floats up
  // pull-up on released pins
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = (pins[i].oe & pins[i].out) | (~pins[i].oe & ~ext_en[i])
                  | (~pins[i].oe & ext_en[i] & ext_val[i]);
    end
  end
endmodule : cio_pin_model
`default_nettype wire

// File: bench/cio_port_top_tb.sv
/* Bench for the I/O port block: registers, pin modes, peripheral buffer.
   Assumes cio_port_top with its checker bound, and cio_pin_model on the pins. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end

module cio_port_top_tb
  import cio_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] cpu_addr = 8'h00;
  logic [7:0] cpu_wdata = 8'h00;
  logic cpu_wr_strobe = 1'b0;
  logic cpu_rd_strobe = 1'b0;
  logic [7:0] cpu_rdata;
  logic cpu_rdata_valid;
  logic [7:0] addr_latched = 8'hC3;
  logic buf_bit = 1'b0;
  logic program_store_strobe = 1'b0;
  logic region_hit = 1'b1;
  logic sel_one = 1'b0;
  logic [7:0] periph_cpu_data = 8'h3C;
  logic periph_cpu_read = 1'b0;
  logic [7:0] periph_rdata;
  cio_pld_s pld_cfg [0:3] = '{default: '0};
  logic [7:0] pin_in [0:3];
  cio_pins_s pins [0:3];
  logic [7:0] ext_val [0:3] = '{default: '0};
  logic [7:0] ext_en [0:3] = '{default: '0};
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  wire logic sel_zero = program_store_strobe & region_hit;

  cio_port_top dut (
    .clock(clock), .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr_strobe(cpu_wr_strobe), .cpu_rd_strobe(cpu_rd_strobe), .cpu_rdata(cpu_rdata),
    .cpu_rdata_valid(cpu_rdata_valid), .addr_latched(addr_latched),
    .peripheral_buffer_bit(buf_bit), .peripheral_select_zero(sel_zero),
    .peripheral_select_one(sel_one), .periph_cpu_data(periph_cpu_data),
    .periph_cpu_read(periph_cpu_read), .periph_rdata(periph_rdata),
    .pld_cfg(pld_cfg), .pin_in(pin_in), .pins(pins)
  );
  cio_pin_model u_world (.pins(pins), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  ////////////////////////////////////////
  // Clock, and a hang guard far above the 135 or so cycles needed
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_sim();
    end
  end

  // Bus cycles: strobe set at one falling edge, dropped at the next
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr_strobe = 1'b1;
    @(negedge clock);
    cpu_wr_strobe = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    cpu_addr = a;
    cpu_rd_strobe = 1'b1;
    @(negedge clock);
    cpu_rd_strobe = 1'b0;
    `CHK("valid", 1'b1, cpu_rdata_valid)
    `CHK("rdata", e, cpu_rdata)
  endtask : rd
  task automatic fin(input string n);
    $display("test %s done", n);
  endtask : fin
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    for (int p = 0; p < 4; p++) begin
      for (int k = 1; k < 5; k++) rd(8'(k * 16 + p), 8'h00);
      `CHK("oe", 8'h00, pins[p].oe)
    end
    fin("reset");
  endtask : t_reset
  task automatic t_regs;
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'hFF);
    wr(8'h22, 8'hFF);
    rd(8'h22, 8'h00);
    wr(8'h33, 8'hFF);
    rd(8'h33, 8'h06);
    wr(8'h41, 8'hA5);
    rd(8'h41, 8'hA5);
    `CHK("fast", 8'h05, pins[1].fast)
    wr(8'h61, 8'h5A);
    rd(8'h61, 8'h00);
    wr(8'h33, 8'h00);
    wr(8'h30, 8'h00);
    fin("regs");
  endtask : t_regs
  task automatic t_pio;
    wr(8'h31, 8'h07);
    wr(8'h11, 8'h55);
    `CHK("oe", 8'h07, pins[1].oe)
    `CHK("out", 3'h5, pins[1].out[2:0])
    rd(8'h11, 8'h55);
    ext_en[1] = 8'hF8; // outside drives inputs only
    ext_val[1] = 8'hA0;
    repeat (8) @(negedge clock);
    rd(8'h01, 8'hA5);
    ext_en[1] = 8'h00;
    fin("pio");
  endtask : t_pio
  task automatic t_addr;
    wr(8'h20, 8'hFF);
    wr(8'h30, 8'hFF);
    `CHK("out", 8'hC3, pins[0].out)
    wr(8'h30, 8'h0F);
    `CHK("oe", 8'h0F, pins[0].oe)
    wr(8'h20, 8'h00);
    wr(8'h30, 8'h00);
    fin("addr");
  endtask : t_addr
  task automatic t_pld;
    @(negedge clock);
    pld_cfg[2] = {8'hFF, 8'hFF, 8'h04};
    pld_cfg[3].oe_term = 8'hFF;
    @(negedge clock);
    `CHK("oe", 8'h04, pins[2].oe)
    `CHK("out", 8'h9C, pins[2].out)
    `CHK("oe", 8'h06, pins[3].oe)
    pld_cfg = '{default: '0};
    fin("pld");
  endtask : t_pld
  task automatic t_od;
    wr(8'h42, 8'hFF);
    wr(8'h32, 8'hFF);
    wr(8'h12, 8'h0F);
    `CHK("out", 8'h00, pins[2].out)
    `CHK("oe", 8'hF0, pins[2].oe)
    rd(8'h52, 8'hF0);
    repeat (8) @(negedge clock);
    rd(8'h02, 8'h0F);
    wr(8'h40, 8'h0F);
    `CHK("fast", 8'h0F, pins[0].fast)
    wr(8'h43, 8'hFF);
    `CHK("fast", 8'h06, pins[3].fast)
    fin("open_drain");
  endtask : t_od
  task automatic t_periph;
    @(negedge clock);
    buf_bit = 1'b1;
    program_store_strobe = 1'b1;
    @(negedge clock);
    `CHK("oe", 8'hFF, pins[0].oe)
    `CHK("out", 8'h3C, pins[0].out)
    program_store_strobe = 1'b0;
    @(negedge clock);
    `CHK("oe", 8'h00, pins[0].oe)
    sel_one = 1'b1;
    periph_cpu_read = 1'b1;
    ext_en[0] = 8'hFF;
    ext_val[0] = 8'h96;
    repeat (8) @(negedge clock);
    `CHK("periph_rdata", 8'h96, periph_rdata)
    sel_one = 1'b0;
    periph_cpu_read = 1'b0;
    buf_bit = 1'b0;
    fin("periph");
  endtask : t_periph

  // Main sequence
  initial begin
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    t_reset();
    t_regs();
    t_pio();
    t_addr();
    t_pld();
    t_od();
    t_periph();
    end_sim();
  end
endmodule : cio_port_top_tb
`default_nettype wire
